// >>> hw/dmx_exec.sv
// Data-move instruction executor: file-to-file move, literal loads, store
//
// Functional notes
// RL1 - Move: first word 1100 source, second 1111 dest
// RL2 - Full 12-bit addresses, no bank, no flags
// RL3 - Working register may be move source or dest
// RL4 - Programs never target PC low or stack top
// RL5 - Move: source read Q2, dest write Q4 later
// RL6 - Programs avoid moving into interrupt settings
// RL7 - 0000 0001 loads bank select in Q4
// RL8 - 0000 1110 loads working register, no flags
// RL9 - 0110 111a stores working register in one cycle
// RL10 - Store address is within a 256-byte bank
// RL11 - Access bit 0 shared bank, 1 bank select
// RL12 - Lone second move word acts as no-op
`timescale 1ns/10ps
module dmx_exec
  import dmx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic wait_req,
  input wire logic [7:0] mem_rdata,
  output logic fetch_stall,
  output logic [1:0] q_phase,
  output logic [11:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic [7:0] accum,
  output logic [7:0] bank_select_register
);

  ////////////////////////////////////////////////////////////////////////
  // Quarter phases

  dmx_phase_if ph ();

  dmx_quarter u_quarter (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ph(ph)
  );

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    dmx_mode_t mode;
    logic [15:0] ir;
    logic [11:0] dst;
    logic extend;
    logic [7:0] src;
    logic [7:0] accum;
    logic [7:0] bank;
    logic [11:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } dmx_exec_state_t;

  dmx_exec_state_t r;
  dmx_exec_state_t next_r;

  logic [1:0] q;
  logic is_move;
  logic is_store;
  logic [7:0] file_addr;
  logic [11:0] store_addr;
  logic dst_write;

  assign q = ph.q;
  assign is_move = (r.ir[15:12] == DMX_OP_MOVE_FIRST);
  assign is_store = (r.ir[15:9] == DMX_OP_STORE_ACCUM);
  assign file_addr = r.ir[7:0];
  // Access bank: low half at the bottom of data space, high half at the top
  assign store_addr = r.ir[DMX_ACCESS_BIT] ? {r.bank[3:0], file_addr}
                                           : {{4{file_addr[7]}}, file_addr}; // see RL10 RL11
  assign dst_write = (r.mode == DMX_WAIT) || ((r.mode == DMX_SECOND) && !r.extend);

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_r = r;
    next_r.rd = 1'b0;
    next_r.wr = 1'b0;
    unique case (q)
      DMX_Q1: begin
        if (r.mode == DMX_SECOND) begin
          next_r.dst = instr_word[11:0]; // see RL1 RL2
          next_r.extend = wait_req; // see RL5
        end else if (r.mode == DMX_RUN) begin
          next_r.ir = instr_valid ? instr_word : DMX_NOP_WORD;
          if (instr_valid && instr_word[15:12] == DMX_OP_MOVE_FIRST) begin
            next_r.addr = instr_word[11:0]; // see RL2
            next_r.rd = (instr_word[11:0] != DMX_ACCUM_ADDR); // see RL3 RL5
          end
        end
      end
      DMX_Q2: begin
        if (r.mode == DMX_RUN && is_move) begin
          next_r.src = (r.addr == DMX_ACCUM_ADDR) ? r.accum : mem_rdata; // see RL3
        end
      end
      DMX_Q3: begin
        if (r.mode == DMX_RUN && is_store) begin
          next_r.addr = store_addr; // see RL9
          next_r.wr = 1'b1;
          next_r.wdata = r.accum;
        end else if (dst_write && r.dst != DMX_ACCUM_ADDR) begin
          next_r.addr = r.dst; // see RL5
          next_r.wr = 1'b1;
          next_r.wdata = r.src;
        end
      end
      DMX_Q4: begin
        if (r.mode == DMX_RUN) begin
          if (r.ir[15:8] == DMX_OP_LOAD_BANK) begin
            next_r.bank = r.ir[7:0]; // see RL7
          end else if (r.ir[15:8] == DMX_OP_LOAD_ACCUM) begin
            next_r.accum = r.ir[7:0]; // see RL8
          end else if (is_move) begin
            next_r.mode = DMX_SECOND; // see RL1
          end
          // Second word seen alone falls through here doing nothing
        end else if (r.mode == DMX_SECOND && r.extend) begin
          next_r.mode = DMX_WAIT;
          next_r.extend = 1'b0;
        end else begin
          if (r.dst == DMX_ACCUM_ADDR) begin
            next_r.accum = r.src; // see RL3
          end
          next_r.mode = DMX_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r.mode <= DMX_RUN;
      r.ir <= DMX_NOP_WORD;
      r.dst <= 12'h000;
      r.extend <= 1'b0;
      r.src <= 8'h00;
      r.accum <= DMX_ACCUM_RESET;
      r.bank <= DMX_BANK_RESET;
      r.addr <= 12'h000;
      r.rd <= 1'b0;
      r.wr <= 1'b0;
      r.wdata <= 8'h00;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign fetch_stall = (r.mode == DMX_WAIT);
  assign q_phase = q;
  assign mem_addr = r.addr;
  assign mem_rd = r.rd;
  assign mem_wr = r.wr;
  assign mem_wdata = r.wdata;
  assign accum = r.accum;
  assign bank_select_register = r.bank;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  logic take;
  assign take = (q == DMX_Q1) && (r.mode == DMX_RUN) && instr_valid;

  a_move_src_read: assert property ( // see RL1
    take && instr_word[15:12] == DMX_OP_MOVE_FIRST && instr_word[11:0] != DMX_ACCUM_ADDR
    |=> mem_rd && mem_addr == $past(instr_word[11:0]) && !mem_wr
  ) else $error("move source read missing or wrong address");

  a_move_dst_write: assert property ( // see RL5
    (q == DMX_Q1) && (r.mode == DMX_SECOND) && !wait_req
    && instr_word[11:0] != DMX_ACCUM_ADDR
    |=> !mem_wr [*2] ##1 mem_wr && mem_addr == $past(instr_word[11:0], 3)
        && mem_wdata == r.src
  ) else $error("move destination write not in fourth quarter");

  a_move_extended: assert property ( // see RL5
    (q == DMX_Q1) && (r.mode == DMX_SECOND) && wait_req
    && instr_word[11:0] != DMX_ACCUM_ADDR
    |=> !mem_wr [*6] ##1 mem_wr && fetch_stall
  ) else $error("extended move did not write in third cycle");

  a_move_accum_src: assert property ( // see RL3
    take && instr_word[15:12] == DMX_OP_MOVE_FIRST && instr_word[11:0] == DMX_ACCUM_ADDR
    |=> !mem_rd ##1 r.src == accum
  ) else $error("working register source not used");

  a_write_quarter: assert property ( // see RL5
    mem_wr |-> q == DMX_Q4
  ) else $error("data write outside fourth quarter");

  a_bank_load: assert property ( // see RL7
    take && instr_word[15:8] == DMX_OP_LOAD_BANK
    |=> ##3 bank_select_register == $past(instr_word[7:0], 4) && !mem_wr
  ) else $error("bank select literal not loaded");

  a_accum_load: assert property ( // see RL8
    take && instr_word[15:8] == DMX_OP_LOAD_ACCUM
    |=> ##3 accum == $past(instr_word[7:0], 4)
  ) else $error("working register literal not loaded");

  a_store_access: assert property ( // see RL9 RL11
    take && instr_word[15:9] == DMX_OP_STORE_ACCUM && !instr_word[DMX_ACCESS_BIT]
    |=> ##2 mem_wr && mem_wdata == accum
        && mem_addr == {{4{$past(instr_word[7], 3)}}, $past(instr_word[7:0], 3)}
  ) else $error("access bank store wrong");

  a_store_banked: assert property ( // see RL10 RL11
    take && instr_word[15:9] == DMX_OP_STORE_ACCUM && instr_word[DMX_ACCESS_BIT]
    |=> ##2 mem_wr && mem_addr == {bank_select_register[3:0], $past(instr_word[7:0], 3)}
  ) else $error("banked store wrong");

  a_orphan_nop: assert property ( // see RL12
    take && instr_word[15:12] == DMX_OP_MOVE_SECOND
    |=> !mem_rd ##1 !mem_wr [*3] ##1 r.mode == DMX_RUN && $stable(accum)
  ) else $error("lone second move word had an effect");

  c_move_done: cover property (
    (r.mode == DMX_SECOND) && mem_wr
  );
  c_move_extended: cover property (
    (r.mode == DMX_WAIT) && mem_wr
  );
  c_store_banked: cover property (
    take && instr_word[15:9] == DMX_OP_STORE_ACCUM && instr_word[DMX_ACCESS_BIT]
  );

endmodule : dmx_exec

// >>> hw/dmx_pkg.sv
// Shared constants and types of the data-move instruction executor
package dmx_pkg;

  // Quarter phases of one instruction cycle
  localparam logic [1:0] DMX_Q1 = 2'h0;
  localparam logic [1:0] DMX_Q2 = 2'h1;
  localparam logic [1:0] DMX_Q3 = 2'h2;
  localparam logic [1:0] DMX_Q4 = 2'h3;

  // Opcode fields
  localparam logic [3:0] DMX_OP_MOVE_FIRST = 4'hc;
  localparam logic [3:0] DMX_OP_MOVE_SECOND = 4'hf;
  localparam logic [7:0] DMX_OP_LOAD_BANK = 8'h01;
  localparam logic [7:0] DMX_OP_LOAD_ACCUM = 8'h0e;
  localparam logic [6:0] DMX_OP_STORE_ACCUM = 7'h37;
  localparam int DMX_ACCESS_BIT = 8;

  // Data space location that stands for the working register
  localparam logic [11:0] DMX_ACCUM_ADDR = 12'hfe8;

  // Reset values
  localparam logic [7:0] DMX_ACCUM_RESET = 8'h00;
  localparam logic [7:0] DMX_BANK_RESET = 8'h00;
  localparam logic [15:0] DMX_NOP_WORD = 16'h0000;

  typedef enum logic [1:0] {
    DMX_RUN,
    DMX_SECOND,
    DMX_WAIT
  } dmx_mode_t;

endpackage : dmx_pkg

// >>> hw/dmx_phase_if.sv
// Quarter phase carrier between the phase generator and the executor
`timescale 1ns/10ps
interface dmx_phase_if;
  logic [1:0] q;
  modport gen (output q);
  modport use_side (input q);
endinterface : dmx_phase_if

// >>> hw/dmx_quarter.sv
// Quarter phase generator: one clock per quarter, four per instruction cycle
`timescale 1ns/10ps
module dmx_quarter
  import dmx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  dmx_phase_if.gen ph
);

  typedef struct packed {
    logic [1:0] q;
  } dmx_quarter_state_t;

  dmx_quarter_state_t r;
  dmx_quarter_state_t next_r;

  always_comb begin
    next_r = r;
    next_r.q = r.q + 2'h1;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r.q <= DMX_Q1;
    end else begin
      r <= next_r;
    end
  end

  assign ph.q = r.q;

endmodule : dmx_quarter

// >>> tb/dmx_mem_model.sv
// Data memory model that answers the executor's strobes
`timescale 1ns/10ps
module dmx_mem_model (
  input wire logic clk_sys,
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [4096];
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = i[7:0];
    end
  end
  // Data valid only under the read strobe, inverted otherwise
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
  always @(posedge clk_sys) begin
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule : dmx_mem_model

// >>> tb/dmx_exec_tb_top.sv
// Self-checking bench of the data-move instruction executor
`timescale 1ns/10ps
module dmx_exec_tb_top;
  import dmx_pkg::*;
  typedef struct packed {
    logic [15:0] w;
    logic [1:0] k;
    logic [11:0] a;
    logic [7:0] d;
  } dmx_row_t;
  logic clk_sys, rst_n, instr_valid, wait_req, fetch_stall, mem_rd, mem_wr;
  logic [15:0] instr_word;
  logic [11:0] mem_addr;
  logic [1:0] q_phase;
  logic [7:0] mem_rdata, mem_wdata, accum, bank_select_register;
  int mismatches = 0, checks = 0, cycles = 0, reads = 0, n;
  // Kind: 0 none, 1 memory byte, 2 working register, 3 bank select
  // Program never targets stack or interrupt settings
  dmx_row_t rows [12] = '{
    '{16'h0e3c, 2'h2, 12'h000, 8'h3c},
    '{16'h0105, 2'h3, 12'h000, 8'h05},
    '{16'h6f10, 2'h1, 12'h510, 8'h3c},
    '{16'h6e90, 2'h1, 12'hf90, 8'h3c},
    '{16'h6e20, 2'h1, 12'h020, 8'h3c},
    '{16'hc123, 2'h0, 12'h000, 8'h00},
    '{16'hfabc, 2'h1, 12'habc, 8'h23},
    '{16'hcfe8, 2'h0, 12'h000, 8'h00},
    '{16'hf000, 2'h1, 12'h000, 8'h3c},
    '{16'hcfff, 2'h0, 12'h000, 8'h00},
    '{16'hffe8, 2'h2, 12'h000, 8'hff},
    '{16'hf456, 2'h1, 12'h456, 8'h56}
  };

  dmx_exec i_dmx_exec (.clk_sys(clk_sys), .rst_n(rst_n), .instr_word(instr_word),
    .instr_valid(instr_valid), .wait_req(wait_req), .mem_rdata(mem_rdata),
    .fetch_stall(fetch_stall), .q_phase(q_phase), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .accum(accum),
    .bank_select_register(bank_select_register));
  dmx_mem_model i_dmx_mem_model (.clk_sys(clk_sys), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp8
  task automatic cmp1(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp1
  task automatic conclude;
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  // One instruction slot: inputs land just after a Q1-start edge
  task automatic step(input logic [15:0] w, input logic v, input logic wq);
    instr_word <= w;
    instr_valid <= v;
    wait_req <= wq;
    repeat (4) @(posedge clk_sys);
  endtask : step
  task automatic check_row(input dmx_row_t r);
    case (r.k)
      2'h1: cmp8("memory", r.d, i_dmx_mem_model.mem[r.a]);
      2'h2: cmp8("accum", r.d, accum);
      2'h3: cmp8("bank", r.d, bank_select_register);
      default: ;
    endcase
  endtask : check_row

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (mem_rd === 1'b1) begin
      reads <= reads + 1;
    end
    if (cycles == 1000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    rst_n = 1'b0;
    instr_word = DMX_NOP_WORD;
    instr_valid = 1'b0;
    wait_req = 1'b0;
    repeat (8) @(posedge clk_sys);
    cmp1("mem_wr", 1'b0, mem_wr);
    cmp1("mem_rd", 1'b0, mem_rd);
    cmp8("accum", DMX_ACCUM_RESET, accum);
    cmp8("bank", DMX_BANK_RESET, bank_select_register);
    cmp8("q_phase", 8'(DMX_Q1), 8'(q_phase));
    rst_n <= 1'b1;
    for (int i = 0; i <= 12; i++) begin
      step(i < 12 ? rows[i].w : DMX_NOP_WORD, 1'b1, 1'b0);
      if (i > 0) begin
        check_row(rows[i - 1]);
      end
    end
    // Extended move, second word without valid, word offered in the stall
    n = reads;
    step(16'hc234, 1'b1, 1'b0);
    step(16'hf345, 1'b0, 1'b1);
    instr_word <= 16'h0e77;
    instr_valid <= 1'b1;
    wait_req <= 1'b0;
    @(negedge clk_sys);
    cmp1("fetch_stall", 1'b1, fetch_stall);
    cmp8("q_phase", 8'(DMX_Q1), 8'(q_phase));
    repeat (4) @(posedge clk_sys);
    step(DMX_NOP_WORD, 1'b1, 1'b0);
    step(DMX_NOP_WORD, 1'b1, 1'b0);
    cmp8("memory", 8'h34, i_dmx_mem_model.mem[12'h345]);
    cmp8("accum", 8'hff, accum);
    cmp8("reads", 8'h01, 8'(reads - n));
    cmp1("fetch_stall", 1'b0, fetch_stall);
    // Reset in mid-move abandons it; a word without valid is a no-op
    step(16'hc456, 1'b1, 1'b0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    cmp1("mem_wr", 1'b0, mem_wr);
    cmp1("fetch_stall", 1'b0, fetch_stall);
    cmp8("q_phase", 8'(DMX_Q1), 8'(q_phase));
    cmp8("accum", DMX_ACCUM_RESET, accum);
    cmp8("bank", DMX_BANK_RESET, bank_select_register);
    rst_n <= 1'b1;
    step(16'h0e5a, 1'b1, 1'b0);
    step(16'h0e33, 1'b0, 1'b0);
    step(16'hf111, 1'b1, 1'b0);
    step(DMX_NOP_WORD, 1'b1, 1'b0);
    cmp8("accum", 8'h5a, accum);
    cmp8("memory", 8'h11, i_dmx_mem_model.mem[12'h111]);
    conclude();
  end
endmodule : dmx_exec_tb_top
